// File: common/rmsd_consts.svh
// Constants for the register map select decoder.
`ifndef RMSD_CONSTS_SVH
`define RMSD_CONSTS_SVH
`define RMSD_MAIN_ADDR_HI  6'h20
`define RMSD_SUBSEL_OFS    8'h0e
`define RMSD_SUBSEL_LSB    5
`define RMSD_SUBSEL_RST    2'h0
`define RMSD_OUTADDR_OFS   8'hfe
`define RMSD_OUTADDR_RST   8'h00
`define RMSD_SUBADDR_MAX   8'hff
`endif

// File: common/rmsd_pkg.sv
// Types shared by the register map select decoder.
`default_nettype none
package rmsd_pkg;
  typedef enum logic [1:0] {
    RMSD_MAP_USER   = 2'b00,
    RMSD_MAP_INTVBI = 2'b01,
    RMSD_MAP_USER2  = 2'b10,
    RMSD_MAP_OUT    = 2'b11
  } rmsd_map_t;

  typedef enum logic [3:0] {
    RMSD_IDLE = 4'b0000,
    RMSD_DEV  = 4'b0001,
    RMSD_ADEV = 4'b0010,
    RMSD_SUB  = 4'b0011,
    RMSD_SCHK = 4'b0100,
    RMSD_ASUB = 4'b0101,
    RMSD_WR   = 4'b0110,
    RMSD_AWR  = 4'b0111,
    RMSD_RNXT = 4'b1000,
    RMSD_RD   = 4'b1001,
    RMSD_RACK = 4'b1010
  } rmsd_st_t;

  typedef struct packed {
    rmsd_map_t  map;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rmsd_req_t;

  typedef struct packed {
    rmsd_st_t   st;
    logic [2:0] cnt;
    logic       got;
    logic [7:0] sh;
    logic       scl_q;
    logic       sda_q;
    logic       rw;
    rmsd_req_t  req;
    logic       sda_oe;
    logic       sda_out;
    logic [1:0] subsel;
    logic [7:0] outaddr;
  } rmsd_state_t;
endpackage
`default_nettype wire

// File: hw/rmsd_decoder.sv
// Two-wire slave front end that decodes device addresses into register maps and sub maps.
`timescale 1ns/1ns
`default_nettype none
`include "rmsd_consts.svh"
module rmsd_decoder (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               address_strap_pin,
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe,
  output rmsd_pkg::rmsd_req_t     req,
  input  wire logic               subaddr_ok,
  input  wire logic [7:0]         rd_data,
  output logic [1:0]              submap_select,
  output logic [7:0]              output_map_device_address
);
  import rmsd_pkg::*;

  rmsd_state_t s;
  rmsd_state_t next_s;
  logic        rise;
  logic        fall;
  logic        start_c;
  logic        stop_c;
  logic [6:0]  dev7;
  logic        main_hit;
  logic        out_hit;
  rmsd_map_t   sel_map;
  logic        sel_reg_hit;
  logic        out_reg_hit;
  logic        sub_ok;
  logic [7:0]  rdval;
  logic [7:0]  addr_inc;
  logic        byte_end;

  assign rise     = scl_in & ~s.scl_q;
  assign fall     = ~scl_in & s.scl_q;
  assign start_c  = s.scl_q & scl_in & s.sda_q & ~sda_in;
  assign stop_c   = s.scl_q & scl_in & ~s.sda_q & sda_in;
  assign dev7     = s.sh[7:1];
  assign byte_end = fall & s.got;
  // strap drives bit one of the address byte
  assign main_hit = (dev7 == {`RMSD_MAIN_ADDR_HI >> 1, address_strap_pin});
  // strap and select play no part
  assign out_hit  = (s.outaddr[7:1] != 7'h00) && (dev7 == s.outaddr[7:1]);

  // The select register appears in every main sub map so it can always be rewritten.
  assign sel_reg_hit = (s.req.map != RMSD_MAP_OUT) && (s.req.addr == `RMSD_SUBSEL_OFS);
  assign out_reg_hit = (s.req.map == RMSD_MAP_USER) && (s.req.addr == `RMSD_OUTADDR_OFS);
  assign sub_ok      = sel_reg_hit | out_reg_hit | subaddr_ok;
  assign addr_inc    = (s.req.addr == `RMSD_SUBADDR_MAX) ? s.req.addr : s.req.addr + 8'h01;

  always_comb begin
    rdval = rd_data;
    if (sel_reg_hit) begin
      rdval = 8'h00;
      rdval[`RMSD_SUBSEL_LSB +: 2] = s.subsel;
    end else if (out_reg_hit) begin
      rdval = s.outaddr;
    end
  end

  // three sub maps from one select field
  always_comb begin
    case (s.subsel)
      2'b01: sel_map = RMSD_MAP_INTVBI;
      2'b10: sel_map = RMSD_MAP_USER2;
      // select 11 and 00 reach the user map
      default: sel_map = RMSD_MAP_USER;
    endcase
  end

  always_comb begin
    next_s        = s;
    next_s.scl_q  = scl_in;
    next_s.sda_q  = sda_in;
    next_s.req.wr = 1'b0;
    next_s.req.rd = 1'b0;
    if (start_c) begin
      next_s.st     = RMSD_DEV;
      next_s.cnt    = 3'h0;
      next_s.got    = 1'b0;
      next_s.sda_oe = 1'b0;
    end else if (stop_c) begin
      next_s.st     = RMSD_IDLE;
      next_s.sda_oe = 1'b0;
    end else begin
      case (s.st)
        RMSD_DEV, RMSD_SUB, RMSD_WR: begin
          if (rise) begin
            next_s.sh  = {s.sh[6:0], sda_in};
            next_s.cnt = s.cnt + 3'h1;
            next_s.got = (s.cnt == 3'h7);
          end else if (byte_end) begin
            next_s.got = 1'b0;
            if (s.st == RMSD_DEV) begin
              // only the two map addresses are answered
              if (main_hit | out_hit) begin
                next_s.req.map = out_hit ? RMSD_MAP_OUT : sel_map;
                next_s.rw      = s.sh[0];
                next_s.sda_oe  = 1'b1;
                next_s.st      = RMSD_ADEV;
              end else begin
                next_s.st = RMSD_IDLE;
              end
            end else if (s.st == RMSD_SUB) begin
              next_s.req.addr = s.sh;
              next_s.st       = RMSD_SCHK;
            end else if (sub_ok) begin
              next_s.req.wdata = s.sh;
              next_s.req.wr    = 1'b1;
              next_s.sda_oe    = 1'b1;
              next_s.st        = RMSD_AWR;
              if (sel_reg_hit) begin
                next_s.subsel = s.sh[`RMSD_SUBSEL_LSB +: 2];
              end
              if (out_reg_hit) begin
                next_s.outaddr = s.sh;
              end
            end else begin
              // no acknowledge for data beyond the map
              next_s.st = RMSD_IDLE;
            end
          end
        end
        RMSD_SCHK: begin
          if (sub_ok) begin
            next_s.sda_oe = 1'b1;
            next_s.st     = RMSD_ASUB;
          end else begin
            next_s.st = RMSD_IDLE;
          end
        end
        RMSD_ADEV: begin
          if (fall) begin
            next_s.sda_oe = 1'b0;
            next_s.st     = s.rw ? RMSD_RNXT : RMSD_SUB;
          end
        end
        RMSD_ASUB: begin
          if (fall) begin
            next_s.sda_oe = 1'b0;
            next_s.st     = RMSD_WR;
          end
        end
        RMSD_AWR: begin
          if (fall) begin
            next_s.sda_oe   = 1'b0;
            next_s.req.addr = addr_inc;
            next_s.st       = RMSD_WR;
          end
        end
        RMSD_RNXT: begin
          next_s.sh     = rdval;
          next_s.sda_oe = ~rdval[7];
          next_s.cnt    = 3'h0;
          next_s.req.rd = 1'b1;
          next_s.st     = RMSD_RD;
        end
        RMSD_RD: begin
          if (fall) begin
            next_s.cnt = s.cnt + 3'h1;
            if (s.cnt == 3'h7) begin
              next_s.sda_oe = 1'b0;
              next_s.got    = 1'b0;
              next_s.st     = RMSD_RACK;
            end else begin
              next_s.sh     = {s.sh[6:0], 1'b0};
              next_s.sda_oe = ~s.sh[6];
            end
          end
        end
        RMSD_RACK: begin
          if (rise) begin
            next_s.got = ~sda_in;
            if (sda_in) begin
              next_s.st = RMSD_IDLE;
            end
          end else if (byte_end) begin
            next_s.got      = 1'b0;
            next_s.req.addr = addr_inc;
            next_s.st       = RMSD_RNXT;
          end
        end
        default: next_s.st = RMSD_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s         <= '0;
      s.st      <= RMSD_IDLE;
      // The line samples start at the idle bus level so no false edge follows reset.
      s.scl_q   <= 1'b1;
      s.sda_q   <= 1'b1;
      s.subsel  <= `RMSD_SUBSEL_RST;
      s.outaddr <= `RMSD_OUTADDR_RST;
    end else begin
      s <= next_s;
    end
  end

  assign sda_out                   = s.sda_out;
  assign sda_oe                    = s.sda_oe;
  assign req                       = s.req;
  assign submap_select             = s.subsel;
  assign output_map_device_address = s.outaddr;

  logic dev_done;
  assign dev_done = (s.st == RMSD_DEV) && byte_end && !start_c && !stop_c;

  a_reset_select: assert property (@(posedge ref_clk) $rose(rst_n) |-> s.subsel == 2'h0)
    else $error("select field not cleared by reset");
  a_reset_outaddr: assert property (@(posedge ref_clk) $rose(rst_n) |-> s.outaddr == 8'h00)
    else $error("output map address not cleared by reset");
  a_main_addr_ack: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dev_done && (s.sh[7:1] == {6'h20 >> 1, address_strap_pin}) |=> sda_oe && s.st == RMSD_ADEV)
    else $error("main map address not acknowledged");
  a_submap_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dev_done && main_hit && !out_hit |=> req.map == (($past(s.subsel) == 2'b01) ? RMSD_MAP_INTVBI :
      ($past(s.subsel) == 2'b10) ? RMSD_MAP_USER2 : RMSD_MAP_USER))
    else $error("main access routed to wrong sub map");
  a_out_silent: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dev_done && !main_hit && s.outaddr[7:1] == 7'h00 |=> s.st == RMSD_IDLE && !sda_oe)
    else $error("output map answered before its address was set");
  a_out_decode: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dev_done && s.outaddr[7:1] != 7'h00 && s.sh[7:1] == s.outaddr[7:1] |=> req.map == RMSD_MAP_OUT ##0 sda_oe)
    else $error("output map address not decoded");
  a_bad_subaddr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s.st == RMSD_SCHK && !sub_ok && !start_c && !stop_c |=> s.st == RMSD_IDLE && !sda_oe)
    else $error("unknown subaddress was acknowledged");
  a_read_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s.st == RMSD_ADEV && fall && s.rw && !start_c && !stop_c |=> ##1 req.rd && s.st == RMSD_RD)
    else $error("read bit did not start a read");
  a_sel_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s.st == RMSD_WR && byte_end && sel_reg_hit && !start_c && !stop_c |=> s.subsel == $past(s.sh[6:5]))
    else $error("select write not stored");

  c_main_write: cover property (@(posedge ref_clk) disable iff (!rst_n) req.wr && req.map == RMSD_MAP_USER);
  c_intvbi_read: cover property (@(posedge ref_clk) disable iff (!rst_n) req.rd && req.map == RMSD_MAP_INTVBI);
  c_user2_write: cover property (@(posedge ref_clk) disable iff (!rst_n) req.wr && req.map == RMSD_MAP_USER2);
  c_out_access: cover property (@(posedge ref_clk) disable iff (!rst_n) req.wr && req.map == RMSD_MAP_OUT);
endmodule
`default_nettype wire

// File: test/rmsd_master.sv
// Two-wire bus master model that drives the serial clock and pulls the data line low.
`timescale 1ns/1ns
`default_nettype none
module rmsd_master (
  input  wire logic ref_clk,
  input  wire logic sda_wire,
  output var logic  scl,
  output var logic  sda_low
);
  // Extra low-phase cycles; the bench raises it to act as a slow master.
  int lo = 2;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Data only moves while the clock is low, so a start also serves as a repeated start.
  task automatic start();
    sda_low = 1'b0;
    wt(lo);
    scl = 1'b1;
    wt(4);
    sda_low = 1'b1;
    wt(4);
    scl = 1'b0;
    wt(2);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    wt(lo);
    scl = 1'b1;
    wt(4);
    sda_low = 1'b0;
    wt(4);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    wt(lo);
    scl = 1'b1;
    wt(2);
    r = sda_wire;
    wt(2);
    scl = 1'b0;
    wt(2);
  endtask
  // A byte goes out MSB first and the ninth bit is the acknowledge.
  task automatic byte_io(input logic [7:0] d, input logic nack, output logic [7:0] r, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      r[i] = b;
    end
    bit_io(nack, b);
    ack = !b;
  endtask
endmodule
`default_nettype wire

// File: test/tb_register_map_select_decoder.sv
// Self-checking bench for the register map select decoder.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; $display("Error %0t: got %h exp %h", $time, (a), (e)); end end
module tb_register_map_select_decoder;
  import rmsd_pkg::*;
  logic       ref_clk;
  logic       rst_n;
  logic       strap;
  logic       scl;
  logic       m_low;
  logic       sda_oe;
  logic       sda_o;
  logic       sda_wire;
  logic       subaddr_ok;
  logic [7:0] rd_data;
  logic [1:0] sel;
  logic [7:0] oaddr;
  logic [2:0] a;
  logic [7:0] d;
  rmsd_req_t  req;
  rmsd_req_t  last_wr;
  int         err_total;
  int         n_compared;
  // Open drain wire: the device's driven level only shows while its enable is high.
  assign sda_wire = (sda_oe ? sda_o : 1'b1) & !m_low;
  // Map contents: each byte reads back its own map code and the low six bits of its subaddress; 0xf0 does not exist.
  assign subaddr_ok = (req.addr != 8'hf0);
  assign rd_data = {req.map, req.addr[5:0]};
  always @(posedge ref_clk) if (req.wr === 1'b1) last_wr <= req;
  rmsd_decoder i_rmsd_decoder (
    .ref_clk                   (ref_clk),
    .rst_n                     (rst_n),
    .address_strap_pin         (strap),
    .scl_in                    (scl),
    .sda_in                    (sda_wire),
    .sda_out                   (sda_o),
    .sda_oe                    (sda_oe),
    .req                       (req),
    .subaddr_ok                (subaddr_ok),
    .rd_data                   (rd_data),
    .submap_select             (sel),
    .output_map_device_address (oaddr)
  );
  rmsd_master i_rmsd_master (
    .ref_clk  (ref_clk),
    .sda_wire (sda_wire),
    .scl      (scl),
    .sda_low  (m_low)
  );
  task automatic wrap_up();
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] dev, input logic [7:0] sub, input logic [7:0] v, output logic [2:0] k);
    logic [7:0] r;
    i_rmsd_master.start();
    i_rmsd_master.byte_io(dev, 1'b1, r, k[2]);
    i_rmsd_master.byte_io(sub, 1'b1, r, k[1]);
    i_rmsd_master.byte_io(v, 1'b1, r, k[0]);
    i_rmsd_master.stop();
  endtask
  task automatic rd(input logic [7:0] dev, input logic [7:0] sub, output logic [7:0] v, output logic [2:0] k);
    logic x;
    i_rmsd_master.start();
    i_rmsd_master.byte_io(dev, 1'b1, v, k[2]);
    i_rmsd_master.byte_io(sub, 1'b1, v, k[1]);
    i_rmsd_master.start();
    i_rmsd_master.byte_io(dev | 8'h01, 1'b1, v, k[0]);
    i_rmsd_master.byte_io(8'hff, 1'b1, v, x);
    i_rmsd_master.stop();
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    strap = 1'b0;
    err_total = 0;
    n_compared = 0;
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    `CHK(sel, 2'h0)
    `CHK(oaddr, 8'h00)
    rd(8'h40, 8'h10, d, a);
    `CHK({a, d}, {3'b111, 8'h10})
    wr(8'h42, 8'h10, 8'h5a, a);
    `CHK(a[2], 1'b0)
    wr(8'h88, 8'h10, 8'h00, a);
    `CHK(a[2], 1'b0)
    for (int s = 0; s < 4; s++) begin
      wr(8'h40, 8'h0e, 8'(s << 5), a);
      `CHK({a, sel}, {3'b111, 2'(s)})
      wr(8'h40, 8'h21, 8'ha5, a);
      `CHK({a, last_wr.map, last_wr.addr, last_wr.wdata}, {3'b111, 2'(s == 3 ? 0 : s), 8'h21, 8'ha5})
      rd(8'h40, 8'h0e, d, a);
      `CHK({a, d}, {3'b111, 8'(s << 5)})
    end
    // A read through the second user sub map returns that map's code in the top bits.
    wr(8'h40, 8'h0e, 8'h40, a);
    rd(8'h40, 8'h10, d, a);
    `CHK({a, d}, {3'b111, 8'h90})
    wr(8'h40, 8'h0e, 8'h00, a);
    `CHK({a, sel}, {3'b111, 2'h0})
    wr(8'h40, 8'hfe, 8'h88, a);
    `CHK({a, oaddr}, {3'b111, 8'h88})
    wr(8'h40, 8'h0e, 8'h20, a);
    strap = 1'b1;
    i_rmsd_master.lo = 7;
    rd(8'h88, 8'h10, d, a);
    `CHK({a, d}, {3'b111, 8'hd0})
    wr(8'h88, 8'h10, 8'h33, a);
    `CHK({a, last_wr.map, last_wr.addr, last_wr.wdata}, {3'b111, 2'b11, 8'h10, 8'h33})
    rd(8'h42, 8'h10, d, a);
    `CHK({a, d}, {3'b111, 8'h50})
    wr(8'h40, 8'h10, 8'h00, a);
    `CHK(a[2], 1'b0)
    i_rmsd_master.lo = 2;
    wr(8'h42, 8'hf0, 8'h11, a);
    `CHK(a, 3'b100)
    rd(8'h42, 8'h0e, d, a);
    `CHK({a, d}, {3'b111, 8'h20})
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    `CHK({sel, oaddr}, {2'h0, 8'h00})
    wr(8'h88, 8'h10, 8'h00, a);
    `CHK(a[2], 1'b0)
    wrap_up();
  end
endmodule
`default_nettype wire
